/* common/supervisor_regs.svh */
// Command codes, reset values, field positions and the limit table of the
// current and temperature supervisor. Included by the supervisor core.
`ifndef SUPERVISOR_REGS_SVH
`define SUPERVISOR_REGS_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define CMD_PAGE 8'h00
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_ALERT_MASK 8'h1b
`define CMD_OUTPUT_SLEW_RATE 8'h27
`define CMD_OUT_SENSE_RES 8'h38
`define CMD_OC_FAULT_LIMIT 8'h46
`define CMD_OC_WARN_LIMIT 8'h4a
`define CMD_OVER_TEMP_FAULT_LIMIT 8'h4f
`define CMD_OVER_TEMP_WARN_LIMIT 8'h51
`define CMD_UNDER_TEMP_FAULT_LIMIT 8'h53
`define CMD_IIN_WARN_LIMIT 8'h5d
`define CMD_TURN_ON_DELAY 8'h60
`define CMD_TURN_ON_RAMP 8'h61
`define CMD_TURN_ON_TIMEOUT 8'h62
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_WORD 8'h79
`define CMD_OUTPUT_CURRENT_STATUS 8'h7b
`define CMD_STATUS_INPUT 8'h7c
`define CMD_STATUS_TEMP 8'h7d
`define CMD_MODE_CFG 8'hd4
`define CMD_IIN_SENSE_RES 8'he8
`define CMD_OUT_SENSE_TC 8'hf6
`define CMD_EXT_TEMP_SLOPE 8'hf8
`define CMD_EXT_TEMP_BIAS 8'hf9

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_OUTPUT_SLEW 16'haa00
`define RST_OT_FAULT 16'heb20
`define RST_OT_WARN 16'heaa8
`define RST_UT_FAULT 16'he580
`define RST_IIN_WARN 16'hd280
`define RST_TURN_ON_DELAY 16'h8000
`define RST_TURN_ON_RAMP 16'hd200
`define RST_TURN_ON_TIMEOUT 16'hd280
`define RST_IIN_SENSE_RES 16'hca80
`define RST_EXT_TEMP_SLOPE 16'h4000
`define RST_EXT_TEMP_BIAS 16'h8000
`define RST_OC_FAULT 16'hdbb8
`define RST_OC_WARN 16'hda80
`define RST_OUT_SENSE_RES 16'hbb9a
`define RST_OUT_SENSE_TC 16'h0000
`define RST_MODE_CFG 16'h0000
`define RST_ALERT_MASK 16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MODE_RANGE_BIT 7
`define SB_NOTA 0
`define SB_TEMP 2
`define SW_INPUT 13
`define SW_IOUT 14
`define SI_OC_FAULT 7
`define SI_OC_WARN 5
`define SIN_IIN_WARN 1
`define ST_OT_FAULT 7
`define ST_OT_WARN 6
`define ST_UT_FAULT 4
`define MASK_OC_FAULT 0
`define MASK_OC_WARN 1
`define MASK_OT_WARN 2
`define MASK_TEMP_FAULT 3

// ----------------------------------------------------------------------
// Arithmetic constants
// ----------------------------------------------------------------------
`define Q_FRAC 8
`define SAT_SHIFT 20
`define TEMP_NOMINAL_C 27
`define TEMP_SLOPE_SHIFT 14
`define PPM_SCALE 1000000
// Sense thresholds in mV times 256, high range first, descending
`define OC_THR_TABLE {16'h4b00, 16'h459a, 16'h404d, 16'h3ae6, 16'h359a, 16'h3033, \
  16'h2ae6, 16'h2580, 16'h3200, 16'h2e66, 16'h2ae6, 16'h274d, 16'h23b3, 16'h201a, \
  16'h1c9a, 16'h1900}

`endif

/* common/supervisor_pkg.sv */
// Types shared by the supervisor core and its testbench.
// Assumes nothing beyond a SystemVerilog compiler.
package supervisor_pkg;

  // --------------------------------------------------------------------
  // Command port
  // --------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic valid;
    logic unsup;
    logic [15:0] rdata;
  } cmd_rsp_t;

  // --------------------------------------------------------------------
  // Per-channel measurements
  // --------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] iout_avg;
    logic [15:0] temp_raw;
    logic in_current_limit;
    logic ramping;
  } chan_meas_t;

  typedef enum logic [3:0] {
    PG_SLEW, PG_OT_FAULT, PG_OT_WARN, PG_UT_FAULT, PG_TURN_ON_DELAY, PG_TURN_ON_RAMP_TIME,
    PG_TON_MAX, PG_TEMP_SLOPE, PG_TEMP_BIAS, PG_OC_FAULT, PG_OC_WARN,
    PG_OUT_RSENSE, PG_OUT_TC, PG_MODE_CFG, PG_COUNT
  } paged_idx_t;

endpackage

/* src/lin11_to_q8.sv */
// Converts a linear word (5-bit signed exponent, 11-bit signed mantissa)
// into a signed fixed value with 8 fraction bits. Purely combinational.
`include "supervisor_regs.svh"
module lin11_to_q8 (
  // Linear word
  input wire logic [15:0] word,
  // Fixed result
  output logic signed [31:0] value
);
  logic signed [4:0] expo;
  logic signed [31:0] mant;
  logic signed [6:0] shift;

  always_comb begin
    expo = signed'(word[15:11]);
    mant = 32'(signed'(word[10:0]));
    shift = 7'(expo) + 7'(`Q_FRAC);
    // Clamp keeps the 11-bit mantissa inside 32 bits
    if (shift > 7'(`SAT_SHIFT)) begin
      shift = 7'(`SAT_SHIFT);
    end
    if (shift >= 7'sd0) begin
      value = mant <<< shift;
    end else begin
      value = mant >>> (-shift);
    end
  end
endmodule // lin11_to_q8

/* src/temp_calibrate.sv */
// Applies slope and bias correction to a raw external temperature.
// Slope is a two's complement word in units of 2^-14.
`include "supervisor_regs.svh"
module temp_calibrate (
  // Raw reading and correction terms
  input wire logic signed [31:0] raw_q8,
  input wire logic [15:0] slope,
  input wire logic signed [31:0] bias_q8,
  // Calibrated reading
  output logic signed [31:0] cal_q8
);
  logic signed [47:0] prod;

  always_comb begin
    prod = 48'(raw_q8) * 48'(signed'(slope));
    cal_q8 = 32'(prod >>> `TEMP_SLOPE_SHIFT) + bias_q8;
  end
endmodule // temp_calibrate

/* src/current_temp_limit_supervisor.sv */
// Limit registers, status flags and alert of a dual-channel controller.
// Assumes a serial front end that turns word commands into cmd_req pulses
// and ADC readings presented together with a one-cycle meas_strobe.
// How it works
// RULE_01: Current-limit operation of a channel sets its overcurrent fault flag.
// RULE_02: Fault limit rounds up to one of eight low-range sense thresholds.
// RULE_03: Range bit set selects the eight high-range thresholds instead.
// RULE_04: Range is bit 7 of the channel's switching mode word.
// RULE_05: Sense resistance scales by one plus coefficient times temperature minus 27.
// RULE_06: Overcurrent fault is not evaluated while the output ramps.
// RULE_07: Overcurrent fault sets output-current status bits and unmasked alert.
// RULE_08: Averaged output current is compared against the warning limit.
// RULE_09: Overcurrent warning sets other-event, output-current bits and unmasked alert.
// RULE_10: Input current over its limit sets input bits and always alerts.
// RULE_11: Input sense resistance is held as a linear exponent-mantissa word.
// RULE_12: Temperature slope is a signed word scaled by two to minus 14.
// RULE_13: Temperature bias word is added to the sensed temperature.
// RULE_14: Calibrated temperature above fault limit declares overtemperature fault.
// RULE_15: Temperature above warning limit sets temperature bits and unmasked alert.
// RULE_16: Calibrated temperature below limit declares undertemperature fault.
// RULE_17: Host without sensor programs minus 275 degrees and ignores the fault.
// RULE_18: Every limit travels and is stored as one whole 16-bit word.
// RULE_19: Each channel holds a turn-on timeout limit word.
// RULE_20: Each channel holds an output slew rate word.
// RULE_21: Sense temperature coefficient is a signed word in ppm per degree.
// RULE_22: Paged words follow the selected page; input words are shared.
`include "supervisor_regs.svh"
module current_temp_limit_supervisor #(
  parameter int NCH = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command port
  input wire supervisor_pkg::cmd_req_t cmd_req,
  output supervisor_pkg::cmd_rsp_t cmd_rsp,
  // Measurements
  input wire logic meas_strobe,
  input wire supervisor_pkg::chan_meas_t [NCH-1:0] meas,
  input wire logic [15:0] iin_meas,
  // Alert and analog limit selection
  output logic alert_n,
  output logic [NCH-1:0] oc_range_hi,
  output logic [NCH-1:0][2:0] oc_thr_sel
);
  import supervisor_pkg::*;

  // --------------------------------------------------------------------
  // Constants and state
  // --------------------------------------------------------------------
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int NPG = PG_COUNT;
  localparam logic signed [31:0] TNOM_Q8 = 32'(`TEMP_NOMINAL_C <<< `Q_FRAC);
  localparam logic signed [79:0] PPM_DIV = 80'(`PPM_SCALE) <<< `Q_FRAC;
  localparam logic [15:0][15:0] THR = `OC_THR_TABLE;

  typedef struct packed {
    logic [NCH-1:0][NPG-1:0][15:0] paged;
    logic [15:0] iin_rsense;
    logic [15:0] iin_warn_lim;
    logic [7:0] page;
    logic [NCH-1:0][15:0] alert_mask;
    logic [NCH-1:0] st_oc_fault;
    logic [NCH-1:0] st_oc_warn;
    logic [NCH-1:0] st_ot_fault;
    logic [NCH-1:0] st_ot_warn;
    logic [NCH-1:0] st_ut_fault;
    logic st_iin_warn;
    cmd_rsp_t rsp;
    logic alert_n;
    logic [NCH-1:0] range_hi;
    logic [NCH-1:0][2:0] thr_sel;
  } state_t;

  state_t s_r, s_nxt;
  logic [4:0] slot;
  logic [CW-1:0] ch;
  logic page_ok;
  logic clr;
  logic [15:0] sw_sel;
  logic signed [31:0] iout_q8 [NCH];
  logic signed [31:0] temp_q8 [NCH];
  logic signed [31:0] otf_q8 [NCH];
  logic signed [31:0] otw_q8 [NCH];
  logic signed [31:0] utf_q8 [NCH];
  logic signed [31:0] ocw_q8 [NCH];
  logic signed [31:0] need_q8 [NCH];
  logic signed [31:0] iin_q8, iin_lim_q8;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function automatic logic [15:0] thr_val(input logic hi, input logic [2:0] i);
    return THR[{hi, i}];
  endfunction

  // Smallest threshold not below the need; saturates at the top entry
  function automatic logic [2:0] round_idx(input logic hi, input logic signed [31:0] need);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (need > signed'({16'h0000, thr_val(hi, 3'(i))})) begin
        n = n + 4'h1;
      end
    end
    return (n > 4'h7) ? 3'h7 : n[2:0];
  endfunction

  function automatic logic [4:0] paged_slot(input logic [7:0] code);
    case (code)
      `CMD_OUTPUT_SLEW_RATE: paged_slot = {1'b1, PG_SLEW};
      `CMD_OVER_TEMP_FAULT_LIMIT: paged_slot = {1'b1, PG_OT_FAULT};
      `CMD_OVER_TEMP_WARN_LIMIT: paged_slot = {1'b1, PG_OT_WARN};
      `CMD_UNDER_TEMP_FAULT_LIMIT: paged_slot = {1'b1, PG_UT_FAULT};
      `CMD_TURN_ON_DELAY: paged_slot = {1'b1, PG_TURN_ON_DELAY};
      `CMD_TURN_ON_RAMP: paged_slot = {1'b1, PG_TURN_ON_RAMP_TIME};
      `CMD_TURN_ON_TIMEOUT: paged_slot = {1'b1, PG_TON_MAX};
      `CMD_EXT_TEMP_SLOPE: paged_slot = {1'b1, PG_TEMP_SLOPE};
      `CMD_EXT_TEMP_BIAS: paged_slot = {1'b1, PG_TEMP_BIAS};
      `CMD_OC_FAULT_LIMIT: paged_slot = {1'b1, PG_OC_FAULT};
      `CMD_OC_WARN_LIMIT: paged_slot = {1'b1, PG_OC_WARN};
      `CMD_OUT_SENSE_RES: paged_slot = {1'b1, PG_OUT_RSENSE};
      `CMD_OUT_SENSE_TC: paged_slot = {1'b1, PG_OUT_TC};
      `CMD_MODE_CFG: paged_slot = {1'b1, PG_MODE_CFG};
      default: paged_slot = 5'h00;
    endcase
  endfunction

  function automatic logic [15:0] paged_reset(input int i);
    case (i)
      PG_SLEW: paged_reset = `RST_OUTPUT_SLEW;
      PG_OT_FAULT: paged_reset = `RST_OT_FAULT;
      PG_OT_WARN: paged_reset = `RST_OT_WARN;
      PG_UT_FAULT: paged_reset = `RST_UT_FAULT;
      PG_TURN_ON_DELAY: paged_reset = `RST_TURN_ON_DELAY;
      PG_TURN_ON_RAMP_TIME: paged_reset = `RST_TURN_ON_RAMP;
      PG_TON_MAX: paged_reset = `RST_TURN_ON_TIMEOUT;
      PG_TEMP_SLOPE: paged_reset = `RST_EXT_TEMP_SLOPE;
      PG_TEMP_BIAS: paged_reset = `RST_EXT_TEMP_BIAS;
      PG_OC_FAULT: paged_reset = `RST_OC_FAULT;
      PG_OC_WARN: paged_reset = `RST_OC_WARN;
      PG_OUT_RSENSE: paged_reset = `RST_OUT_SENSE_RES;
      PG_OUT_TC: paged_reset = `RST_OUT_SENSE_TC;
      default: paged_reset = `RST_MODE_CFG;
    endcase
  endfunction

  function automatic state_t reset_state();
    state_t s;
    s = '0;
    for (int c = 0; c < NCH; c++) begin
      for (int i = 0; i < NPG; i++) begin
        s.paged[c][i] = paged_reset(i);
      end
      s.alert_mask[c] = `RST_ALERT_MASK;
    end
    s.iin_rsense = `RST_IIN_SENSE_RES;
    s.iin_warn_lim = `RST_IIN_WARN;
    s.alert_n = 1'b1;
    return s;
  endfunction

  function automatic logic alert_pending(input state_t s);
    logic p;
    p = s.st_iin_warn;
    for (int c = 0; c < NCH; c++) begin
      p = p | (s.st_oc_fault[c] & ~s.alert_mask[c][`MASK_OC_FAULT]);
      p = p | (s.st_oc_warn[c] & ~s.alert_mask[c][`MASK_OC_WARN]);
      p = p | (s.st_ot_warn[c] & ~s.alert_mask[c][`MASK_OT_WARN]);
      p = p | ((s.st_ot_fault[c] | s.st_ut_fault[c]) & ~s.alert_mask[c][`MASK_TEMP_FAULT]);
    end
    return p;
  endfunction

  function automatic logic [15:0] status_word(input state_t s, input logic [CW-1:0] c);
    logic [15:0] w;
    w = 16'h0000;
    w[`SB_NOTA] = s.st_oc_warn[c] | s.st_iin_warn;
    w[`SB_TEMP] = s.st_ot_warn[c] | s.st_ot_fault[c] | s.st_ut_fault[c];
    w[`SW_IOUT] = s.st_oc_fault[c] | s.st_oc_warn[c];
    w[`SW_INPUT] = s.st_iin_warn;
    return w;
  endfunction

  // --------------------------------------------------------------------
  // Measurement conversion per channel
  // --------------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic signed [31:0] raw_q8, bias_q8, ocf_q8, rs_q8, dtemp, rs_eff;
    logic signed [79:0] corr;
    lin11_to_q8 u_iout (.word(meas[g].iout_avg), .value(iout_q8[g]));
    lin11_to_q8 u_temp (.word(meas[g].temp_raw), .value(raw_q8));
    lin11_to_q8 u_bias (.word(s_r.paged[g][PG_TEMP_BIAS]), .value(bias_q8)); // [RULE_13]
    temp_calibrate u_cal (
      .raw_q8(raw_q8),
      .slope(s_r.paged[g][PG_TEMP_SLOPE]), // [RULE_12]
      .bias_q8(bias_q8),
      .cal_q8(temp_q8[g])
    );
    lin11_to_q8 u_otf (.word(s_r.paged[g][PG_OT_FAULT]), .value(otf_q8[g]));
    lin11_to_q8 u_otw (.word(s_r.paged[g][PG_OT_WARN]), .value(otw_q8[g]));
    lin11_to_q8 u_utf (.word(s_r.paged[g][PG_UT_FAULT]), .value(utf_q8[g]));
    lin11_to_q8 u_ocf (.word(s_r.paged[g][PG_OC_FAULT]), .value(ocf_q8));
    lin11_to_q8 u_ocw (.word(s_r.paged[g][PG_OC_WARN]), .value(ocw_q8[g]));
    lin11_to_q8 u_rs (.word(s_r.paged[g][PG_OUT_RSENSE]), .value(rs_q8));
    // Coefficient is signed ppm per degree, temperature is calibrated
    assign dtemp = temp_q8[g] - TNOM_Q8; // [RULE_05]
    assign corr = (80'(rs_q8) * 80'(signed'(s_r.paged[g][PG_OUT_TC])) * 80'(dtemp)) / PPM_DIV; // [RULE_21]
    assign rs_eff = 32'(80'(rs_q8) + corr); // [RULE_05]
    // Sense voltage needed for the limit, in mV times 256
    assign need_q8[g] = 32'((64'(ocf_q8) * 64'(rs_eff)) >>> `Q_FRAC); // [RULE_02]
  end

  lin11_to_q8 u_iin (.word(iin_meas), .value(iin_q8));
  lin11_to_q8 u_iin_lim (.word(s_r.iin_warn_lim), .value(iin_lim_q8));

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    slot = paged_slot(cmd_req.code);
    ch = s_r.page[CW-1:0];
    page_ok = s_r.page < 8'(NCH);
    clr = 1'b0;
    sw_sel = status_word(s_r, ch);
    s_nxt.rsp = '0;
    s_nxt.rsp.valid = cmd_req.wr | cmd_req.rd;
    if (cmd_req.wr) begin
      if (slot[4] && page_ok) begin
        s_nxt.paged[ch][slot[3:0]] = cmd_req.wdata; // [RULE_18] [RULE_22] [RULE_19] [RULE_20]
      end else if (cmd_req.code == `CMD_PAGE) begin
        s_nxt.page = cmd_req.wdata[7:0];
      end else if (cmd_req.code == `CMD_IIN_SENSE_RES) begin
        s_nxt.iin_rsense = cmd_req.wdata; // [RULE_11] [RULE_22]
      end else if (cmd_req.code == `CMD_IIN_WARN_LIMIT) begin
        s_nxt.iin_warn_lim = cmd_req.wdata; // [RULE_22]
      end else if (cmd_req.code == `CMD_ALERT_MASK && page_ok) begin
        s_nxt.alert_mask[ch] = cmd_req.wdata;
      end else if (cmd_req.code == `CMD_CLEAR_FAULTS) begin
        clr = 1'b1;
      end else begin
        s_nxt.rsp.unsup = 1'b1;
      end
    end else if (cmd_req.rd) begin
      if (slot[4] && page_ok) begin
        s_nxt.rsp.rdata = s_r.paged[ch][slot[3:0]]; // [RULE_18] [RULE_22]
      end else begin
        case (cmd_req.code)
          `CMD_PAGE: s_nxt.rsp.rdata = {8'h00, s_r.page};
          `CMD_IIN_SENSE_RES: s_nxt.rsp.rdata = s_r.iin_rsense;
          `CMD_IIN_WARN_LIMIT: s_nxt.rsp.rdata = s_r.iin_warn_lim;
          `CMD_STATUS_INPUT: s_nxt.rsp.rdata[`SIN_IIN_WARN] = s_r.st_iin_warn;
          default: begin
            if (!page_ok) begin
              s_nxt.rsp.unsup = 1'b1;
            end else begin
              case (cmd_req.code)
                `CMD_ALERT_MASK: s_nxt.rsp.rdata = s_r.alert_mask[ch];
                `CMD_STATUS_BYTE: s_nxt.rsp.rdata = {8'h00, sw_sel[7:0]};
                `CMD_STATUS_WORD: s_nxt.rsp.rdata = sw_sel;
                `CMD_OUTPUT_CURRENT_STATUS: begin
                  s_nxt.rsp.rdata[`SI_OC_FAULT] = s_r.st_oc_fault[ch];
                  s_nxt.rsp.rdata[`SI_OC_WARN] = s_r.st_oc_warn[ch];
                end
                `CMD_STATUS_TEMP: begin
                  s_nxt.rsp.rdata[`ST_OT_FAULT] = s_r.st_ot_fault[ch];
                  s_nxt.rsp.rdata[`ST_OT_WARN] = s_r.st_ot_warn[ch];
                  s_nxt.rsp.rdata[`ST_UT_FAULT] = s_r.st_ut_fault[ch];
                end
                default: s_nxt.rsp.unsup = 1'b1;
              endcase
            end
          end
        endcase
      end
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    for (int c = 0; c < NCH; c++) begin
      s_nxt.st_oc_fault[c] = (s_r.st_oc_fault[c] & ~clr)
        | (meas[c].in_current_limit & ~meas[c].ramping); // [RULE_01] [RULE_06] [RULE_07]
      s_nxt.st_oc_warn[c] = (s_r.st_oc_warn[c] & ~clr)
        | (meas_strobe & (iout_q8[c] > ocw_q8[c])); // [RULE_08] [RULE_09]
      s_nxt.st_ot_fault[c] = (s_r.st_ot_fault[c] & ~clr)
        | (meas_strobe & (temp_q8[c] > otf_q8[c])); // [RULE_14]
      s_nxt.st_ot_warn[c] = (s_r.st_ot_warn[c] & ~clr)
        | (meas_strobe & (temp_q8[c] > otw_q8[c])); // [RULE_15]
      s_nxt.st_ut_fault[c] = (s_r.st_ut_fault[c] & ~clr)
        | (meas_strobe & (temp_q8[c] < utf_q8[c])); // [RULE_16]
      s_nxt.range_hi[c] = s_r.paged[c][PG_MODE_CFG][`MODE_RANGE_BIT]; // [RULE_04]
      s_nxt.thr_sel[c] = round_idx(s_r.paged[c][PG_MODE_CFG][`MODE_RANGE_BIT],
        need_q8[c]); // [RULE_02] [RULE_03]
    end
    s_nxt.st_iin_warn = (s_r.st_iin_warn & ~clr)
      | (meas_strobe & (iin_q8 > iin_lim_q8)); // [RULE_10]
    s_nxt.alert_n = ~alert_pending(s_nxt); // [RULE_07] [RULE_09] [RULE_10] [RULE_15]
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= reset_state();
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cmd_rsp = s_r.rsp;
  assign alert_n = s_r.alert_n;
  assign oc_range_hi = s_r.range_hi;
  assign oc_thr_sel = s_r.thr_sel;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  logic mode_hi0;
  logic signed [31:0] need0;
  logic [15:0] sw0;
  assign mode_hi0 = s_r.paged[0][PG_MODE_CFG][`MODE_RANGE_BIT];
  assign need0 = need_q8[0];
  assign sw0 = status_word(s_r, '0);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  chk_oc_fault_set: assert property ( // [RULE_01]
    meas[0].in_current_limit && !meas[0].ramping |=> s_r.st_oc_fault[0]
      && (s_r.alert_mask[0][`MASK_OC_FAULT] || !alert_n))
    else $error("overcurrent fault not flagged");
  chk_oc_ramp_quiet: assert property ( // [RULE_06]
    !s_r.st_oc_fault[0] && meas[0].ramping |=> !s_r.st_oc_fault[0])
    else $error("overcurrent fault raised during ramp");
  chk_alert_level: assert property ( // [RULE_07]
    alert_n == !alert_pending(s_r))
    else $error("alert does not match pending flags");
  chk_oc_warn_set: assert property ( // [RULE_08]
    meas_strobe && iout_q8[0] > ocw_q8[0] |=> s_r.st_oc_warn[0]
      && sw0[`SB_NOTA] && sw0[`SW_IOUT])
    else $error("overcurrent warning not flagged");
  chk_iin_warn_alert: assert property ( // [RULE_10]
    meas_strobe && iin_q8 > iin_lim_q8 |=> s_r.st_iin_warn && !alert_n)
    else $error("input current warning without alert");
  chk_ot_fault_set: assert property ( // [RULE_14]
    meas_strobe && temp_q8[0] > otf_q8[0] |=> s_r.st_ot_fault[0])
    else $error("overtemperature fault not flagged");
  chk_ot_warn_set: assert property ( // [RULE_15]
    meas_strobe && temp_q8[0] > otw_q8[0] |=> s_r.st_ot_warn[0]
      && sw0[`SB_TEMP])
    else $error("overtemperature warning not flagged");
  chk_ut_fault_set: assert property ( // [RULE_16]
    meas_strobe && temp_q8[0] < utf_q8[0] |=> s_r.st_ut_fault[0])
    else $error("undertemperature fault not flagged");
  chk_range_follow: assert property ( // [RULE_04]
    1'b1 |=> oc_range_hi[0] == $past(mode_hi0))
    else $error("current range does not follow mode bit");
  chk_thr_round_up: assert property ( // [RULE_02]
    1'b1 |=> (oc_thr_sel[0] == 3'h7)
      || (signed'({16'h0000, thr_val(oc_range_hi[0], oc_thr_sel[0])}) >= $past(need0)))
    else $error("threshold below required sense voltage");
  chk_word_answer: assert property ( // [RULE_18]
    cmd_req.rd || cmd_req.wr |=> cmd_rsp.valid ##1 !cmd_rsp.valid || $past(cmd_req.rd || cmd_req.wr))
    else $error("command not answered in one cycle");

  cov_oc_alert: cover property (meas[0].in_current_limit && !meas[0].ramping ##1 !alert_n);
  cov_clear: cover property (!alert_n && cmd_req.wr && cmd_req.code == `CMD_CLEAR_FAULTS ##1 alert_n);
  cov_high_top: cover property (oc_range_hi[0] && oc_thr_sel[0] == 3'h7);
  cov_status_read: cover property (cmd_req.rd && cmd_req.code == `CMD_STATUS_WORD ##1 cmd_rsp.valid);
endmodule // current_temp_limit_supervisor

/* tb/pmbus_host_model.sv */
// Host stand-in on the command port: one word command, then its answer.
// Assumes the supervisor answers at the same edge that takes a command.
module pmbus_host_model (
  // Clock
  clk_sys,
  // Command port
  cmd_req,
  cmd_rsp
);
  timeunit 1ns;
  timeprecision 1ns;
  import supervisor_pkg::*;
  input wire logic clk_sys;
  output supervisor_pkg::cmd_req_t cmd_req;
  input wire supervisor_pkg::cmd_rsp_t cmd_rsp;
  initial cmd_req = '0;
  // Whole word per command, held over exactly one taking edge
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
      output cmd_rsp_t rsp);
    @(negedge clk_sys);
    cmd_req = '{wr: wr, rd: !wr, code: code, wdata: wd};
    @(negedge clk_sys);
    cmd_req = '0;
    rsp = cmd_rsp;
  endtask
endmodule // pmbus_host_model

/* tb/test_current_temp_limit_supervisor.sv */
// Self-checking bench of the limit supervisor: defaults, paging, flags, alert.
// Assumes the host stand-in issues every command; inputs change at falling edges.
module test_current_temp_limit_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  import supervisor_pkg::*;
  logic clk_sys = 0;
  logic rst = 1;
  logic meas_strobe = 0;
  chan_meas_t [1:0] meas = '0;
  logic [15:0] iin_meas = '0;
  logic alert_n;
  logic [1:0] oc_range_hi;
  logic [1:0][2:0] oc_thr_sel;
  cmd_req_t cmd_req;
  cmd_rsp_t cmd_rsp;
  cmd_rsp_t rsp;
  int n_errors = 0;
  int n_checks = 0;
  always #20 clk_sys = ~clk_sys;
  current_temp_limit_supervisor i_current_temp_limit_supervisor (.clk_sys(clk_sys),
    .rst(rst), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .meas_strobe(meas_strobe),
    .meas(meas), .iin_meas(iin_meas), .alert_n(alert_n), .oc_range_hi(oc_range_hi),
    .oc_thr_sel(oc_thr_sel));
  pmbus_host_model i_pmbus_host_model (.clk_sys(clk_sys), .cmd_req(cmd_req),
    .cmd_rsp(cmd_rsp));
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    i_pmbus_host_model.xfer(wr, code, wd, rsp);
    check("valid", 16'(rsp.valid), 16'h0001);
  endtask
  task automatic strobe(input logic [15:0] t, input logic [15:0] i);
    @(negedge clk_sys);
    meas[0].temp_raw = t;
    iin_meas = i;
    meas_strobe = 1;
    @(negedge clk_sys);
    meas_strobe = 0;
    meas[0].temp_raw = 16'h0000;
    iin_meas = 16'h0000;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_defaults();
    logic [23:0] tbl[11] = '{24'h27aa00, 24'h4feb20, 24'h51eaa8, 24'h53e580, 24'h5dd280,
      24'h608000, 24'h61d200, 24'h62d280, 24'he8ca80, 24'hf84000, 24'hf98000};
    foreach (tbl[k]) begin
      cmd(0, tbl[k][23:16], 16'h0000);
      check("default", rsp.rdata, tbl[k][15:0]);
    end
    cmd(0, 8'h99, 16'h0000);
    check("unmapped", 16'(rsp.unsup), 16'h0001);
    $display("defaults done");
  endtask
  task automatic t_paging();
    cmd(1, 8'h00, 16'h0001);
    cmd(1, 8'h4a, 16'h1234);
    cmd(0, 8'h4a, 16'h0000);
    check("page1 word", rsp.rdata, 16'h1234);
    cmd(1, 8'h00, 16'h0000);
    cmd(0, 8'h4a, 16'h0000);
    check("page0 word", rsp.rdata, 16'hda80);
    cmd(1, 8'h00, 16'h0002);
    cmd(0, 8'h4a, 16'h0000);
    check("bad page", 16'(rsp.unsup), 16'h0001);
    cmd(1, 8'h00, 16'h0000);
    $display("paging done");
  endtask
  task automatic t_temp();
    strobe(16'heb48, 16'h0000);
    check("alert", 16'(alert_n), 16'h0000);
    cmd(0, 8'h7d, 16'h0000);
    check("temp status", rsp.rdata, 16'h00c0);
    cmd(0, 8'h78, 16'h0000);
    check("status byte", rsp.rdata, 16'h0004);
    cmd(1, 8'h03, 16'h0000);
    check("alert clear", 16'(alert_n), 16'h0001);
    $display("temperature done");
  endtask
  task automatic t_iin();
    meas[0].iout_avg = 16'hdb00;
    strobe(16'h0000, 16'hd300);
    meas[0].iout_avg = 16'h0000;
    check("alert", 16'(alert_n), 16'h0000);
    cmd(0, 8'h7b, 16'h0000);
    check("iout warn", rsp.rdata, 16'h0020);
    cmd(0, 8'h7c, 16'h0000);
    check("input status", rsp.rdata, 16'h0002);
    cmd(0, 8'h78, 16'h0000);
    check("status byte", rsp.rdata, 16'h0001);
    cmd(0, 8'h79, 16'h0000);
    check("word input", rsp.rdata & 16'h2000, 16'h2000);
    cmd(1, 8'h03, 16'h0000);
    $display("input current done");
  endtask
  task automatic t_limit();
    @(negedge clk_sys);
    meas[0].ramping = 1;
    meas[0].in_current_limit = 1;
    repeat (3) @(negedge clk_sys);
    check("alert ramp", 16'(alert_n), 16'h0001);
    meas[0].ramping = 0;
    repeat (2) @(negedge clk_sys);
    meas[0].in_current_limit = 0;
    check("alert limit", 16'(alert_n), 16'h0000);
    cmd(0, 8'h7b, 16'h0000);
    check("iout status", rsp.rdata, 16'h0080);
    cmd(0, 8'h79, 16'h0000);
    check("word iout", rsp.rdata & 16'h4000, 16'h4000);
    cmd(1, 8'h03, 16'h0000);
    $display("current limit done");
  endtask
  task automatic t_no_sensor();
    strobe(16'h079c, 16'h0000);
    cmd(0, 8'h7d, 16'h0000);
    check("ut status", rsp.rdata, 16'h0010);
    cmd(1, 8'h03, 16'h0000);
    cmd(1, 8'h53, 16'h06ed);
    cmd(1, 8'h1b, 16'h0008);
    strobe(16'h079c, 16'h0000);
    cmd(0, 8'h7d, 16'h0000);
    check("ut ignored", rsp.rdata, 16'h0000);
    check("alert quiet", 16'(alert_n), 16'h0001);
    $display("no sensor done");
  endtask
  task automatic t_range();
    check("thr low", 16'(oc_thr_sel[0]), 16'h0007);
    cmd(1, 8'hd4, 16'h0080);
    @(negedge clk_sys);
    check("range", 16'(oc_range_hi), 16'h0001);
    check("thr high", 16'(oc_thr_sel[0]), 16'h0003);
    $display("range done");
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 0;
    t_defaults();
    t_paging();
    t_temp();
    t_iin();
    t_limit();
    t_no_sensor();
    t_range();
    stop_test();
  end
endmodule // test_current_temp_limit_supervisor
